// >>> logic/sisup_defs.vh
// Constants for the supply and internal supervisor.
`ifndef SISUP_DEFS_VH
`define SISUP_DEFS_VH
`define SISUP_ADR_CFG 4'h0
`define SISUP_ADR_STAT 4'h1
`define SISUP_ADR_LIVE 4'h2
`define SISUP_ADR_MASK 4'h3
`define SISUP_ADR_PAR 4'h4
`define SISUP_CFG_RST 8'h00
`define SISUP_MASK_RST 8'h00
`define SISUP_CFG_NEGHI_BIT 0
`define SISUP_CFG_SECEN_BIT 1
`define SISUP_ST_RSTSEEN 0
`define SISUP_ST_SECLO 1
`define SISUP_ST_SECHI 2
`define SISUP_ST_NEGLO 3
`define SISUP_ST_NEGHI 4
`define SISUP_ST_PLINK 5
`define SISUP_ST_SLINK 6
`define SISUP_ST_PARITY 7
`define SISUP_LS_PERIOD_NS 20000
`define SISUP_LS_WIN_MIN_NS 10000
`define SISUP_LS_WIN_MAX_NS 40000
`define SISUP_CLK_NS 40
`endif

// >>> logic/sisup_top.v
// Supply and internal supervisor with a Wishbone register file.
`timescale 1ns/1ps
`include "sisup_defs.vh"
module sisup_top #(
   parameter LS_PERIOD = (`SISUP_LS_PERIOD_NS / `SISUP_CLK_NS),
   parameter LS_WIN_MIN = ((`SISUP_LS_WIN_MIN_NS + `SISUP_CLK_NS - 1) / `SISUP_CLK_NS),
   parameter LS_WIN_MAX = (`SISUP_LS_WIN_MAX_NS / `SISUP_CLK_NS)
) (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [3:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   output wire irq_o,
   input wire pri_supply_low_i,
   input wire sec_supply_low_i,
   input wire sec_supply_high_i,
   input wire neg_supply_low_i,
   input wire neg_supply_high_i,
   input wire sec_below_reset_i,
   input wire primary_ref_pin_fail_i,
   input wire secondary_ref_pin_fail_i,
   input wire sec_par_inject_i,
   output wire reset_ready_out_n_o,
   output wire fault_b_out_n_o,
   output wire turn_off_req_o,
   output wire sec_reset_o,
   output wire link_alive_status_o
);
   // Every pin input passes two flip-flops before it is read.
   reg [8:0] sync1;
   reg [8:0] sync2;
   always @(posedge clk_i) begin
      if (rst_i) begin
         sync1 <= 9'h000;
         sync2 <= 9'h000;
      end else begin
         sync1 <= {sec_par_inject_i, secondary_ref_pin_fail_i, primary_ref_pin_fail_i,
                   sec_below_reset_i, neg_supply_high_i, neg_supply_low_i,
                   sec_supply_high_i, sec_supply_low_i, pri_supply_low_i};
         sync2 <= sync1;
      end
   end
   wire pri_low;
   wire sec_low;
   wire sec_high;
   wire neg_low;
   wire neg_high;
   wire sec_rst_lvl;
   wire pref_fail;
   wire sref_fail;
   wire spar_inj;
   assign pri_low = sync2[0];
   assign sec_low = sync2[1];
   assign sec_high = sync2[2];
   assign neg_low = sync2[3];
   assign neg_high = sync2[4];
   assign sec_rst_lvl = sync2[5];
   assign pref_fail = sync2[6];
   assign sref_fail = sync2[7];
   assign spar_inj = sync2[8];

   // Parity over the eight configuration bits; stored with the register.
   function par8;
      input [7:0] v;
      begin
         par8 = ^v;
      end
   endfunction

   reg [7:0] cfg;
   reg cfg_par;
   reg [7:0] mask;
   reg mask_par;
   reg [7:0] status;
   reg pri_low_q;
   reg neg_high_q;
   reg [3:0] sec_q;
   wire neg_high_en;
   wire sec_enable;
   wire pri_par_fail;
   wire sec_par_fail;
   wire pri_hold;
   wire sec_hold;
   wire p_err2;
   wire s_err2;
   wire p_ls;
   wire s_ls;
   wire p_alive;
   wire s_alive;
   wire wr;
   wire rd;
   wire [7:0] ev;
   wire sec_fault;
   assign neg_high_en = cfg[`SISUP_CFG_NEGHI_BIT];
   assign sec_enable = cfg[`SISUP_CFG_SECEN_BIT];
   // Checked every cycle, so a flipped bit is caught without any access.
   assign pri_par_fail = (par8(cfg) != cfg_par) || (par8(mask) != mask_par);
   // The secondary copy is modelled by the inject pin.
   assign sec_par_fail = spar_inj;
   assign pri_hold = pri_low | pref_fail | pri_par_fail;
   assign sec_hold = sec_rst_lvl | sref_fail | sec_par_fail;
   assign sec_reset_o = sec_hold;

   sisup_wdog #(
      .PERIOD(LS_PERIOD),
      .WIN_MIN(LS_WIN_MIN),
      .WIN_MAX(LS_WIN_MAX)
   ) u_pri_wdog (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .hold_i(pri_hold),
      .ls_in_i(s_ls),
      .ls_out_o(p_ls),
      .err2_o(p_err2),
      .alive_o(p_alive)
   );

   sisup_wdog #(
      .PERIOD(LS_PERIOD),
      .WIN_MIN(LS_WIN_MIN),
      .WIN_MAX(LS_WIN_MAX)
   ) u_sec_wdog (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .hold_i(sec_hold),
      .ls_in_i(p_ls),
      .ls_out_o(s_ls),
      .err2_o(s_err2),
      .alive_o(s_alive)
   );

   assign link_alive_status_o = p_alive;

   // Events: rising edges of supply faults, link-error pulses, the parity failure level, plus recovery for the primary.
   assign ev[`SISUP_ST_RSTSEEN] = pri_low_q & ~pri_low;
   assign ev[`SISUP_ST_SECLO] = sec_low & ~sec_q[0];
   assign ev[`SISUP_ST_SECHI] = sec_high & ~sec_q[1];
   assign ev[`SISUP_ST_NEGLO] = neg_low & ~sec_q[2];
   assign ev[`SISUP_ST_NEGHI] = neg_high & ~neg_high_q;
   assign ev[`SISUP_ST_PLINK] = p_err2;
   assign ev[`SISUP_ST_SLINK] = s_err2;
   assign ev[`SISUP_ST_PARITY] = pri_par_fail | sec_par_fail;

   // Faults last only while the condition holds, so recovery re-enables.
   assign sec_fault = sec_low | sec_high | neg_low | (neg_high & neg_high_en);
   // Regular emergency turn-off request.
   assign turn_off_req_o = pri_low | sec_fault | sref_fail | sec_par_fail |
                           pri_par_fail | ~sec_enable;
   assign reset_ready_out_n_o = ~pri_hold;
   // The negative overvoltage only reaches fault-B when the reaction is on.
   assign fault_b_out_n_o = ~(sec_fault | pri_par_fail | p_err2 | s_err2 |
                              (|status[`SISUP_ST_SLINK:`SISUP_ST_PLINK]));

   assign wr = cyc_i & stb_i & we_i & ~ack_o;
   assign rd = cyc_i & stb_i & ~we_i & ~ack_o;
   assign irq_o = |(status & mask);

   always @(posedge clk_i) begin
      if (rst_i) begin
         cfg <= `SISUP_CFG_RST;
         cfg_par <= 1'b0;
         mask <= `SISUP_MASK_RST;
         mask_par <= 1'b0;
         status <= 8'h00;
         pri_low_q <= 1'b0;
         neg_high_q <= 1'b0;
         sec_q <= 4'h0;
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         pri_low_q <= pri_low;
         neg_high_q <= neg_high;
         sec_q <= {1'b0, neg_low, sec_high, sec_low};
         ack_o <= cyc_i & stb_i & ~ack_o;
         // A read clears status, but an event in the same cycle survives.
         if (rd && adr_i == `SISUP_ADR_STAT) begin
            status <= ev;
         end else begin
            status <= status | ev;
         end
         if (wr && sel_i[0] && adr_i == `SISUP_ADR_CFG) begin
            cfg <= dat_i[7:0];
            cfg_par <= par8(dat_i[7:0]);
         end
         if (wr && sel_i[0] && adr_i == `SISUP_ADR_MASK) begin
            mask <= dat_i[7:0];
            mask_par <= par8(dat_i[7:0]);
         end
         if (rd) begin
            case (adr_i)
               `SISUP_ADR_CFG: dat_o <= {24'h000000, cfg};
               `SISUP_ADR_STAT: dat_o <= {24'h000000, status};
               `SISUP_ADR_LIVE: dat_o <= {27'h0, p_alive, neg_high, neg_low,
                                          sec_high, sec_low};
               `SISUP_ADR_MASK: dat_o <= {24'h000000, mask};
               `SISUP_ADR_PAR: dat_o <= {30'h0, mask_par, cfg_par};
               default: dat_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // sisup_top

// >>> logic/sisup_wdog.v
// Lifesign sender and window checker for one die.
`timescale 1ns/1ps
module sisup_wdog #(
   parameter PERIOD = 500,
   parameter WIN_MIN = 250,
   parameter WIN_MAX = 1000
) (
   input wire clk_i,
   input wire rst_i,
   input wire hold_i,
   input wire ls_in_i,
   output reg ls_out_o,
   output reg err2_o,
   output reg alive_o
);
   reg [15:0] tx_cnt;
   reg [15:0] rx_cnt;
   reg [1:0] err_cnt;
   reg ls_in_q;
   wire ls_edge;
   wire rx_bad;
   assign ls_edge = ls_in_i & ~ls_in_q;
   // Early or missing lifesigns both count as an error.
   assign rx_bad = (ls_edge && rx_cnt < WIN_MIN) || (rx_cnt >= WIN_MAX);
   always @(posedge clk_i) begin
      if (rst_i || hold_i) begin
         tx_cnt <= 16'h0000;
         rx_cnt <= 16'h0000;
         err_cnt <= 2'h0;
         ls_in_q <= 1'b0;
         ls_out_o <= 1'b0;
         err2_o <= 1'b0;
         alive_o <= 1'b0;
      end else begin
         ls_in_q <= ls_in_i;
         ls_out_o <= 1'b0;
         err2_o <= 1'b0;
         if (tx_cnt == PERIOD - 1) begin
            tx_cnt <= 16'h0000;
            ls_out_o <= 1'b1;
         end else begin
            tx_cnt <= tx_cnt + 16'h0001;
         end
         if (ls_edge || rx_bad) begin
            rx_cnt <= 16'h0000;
         end else begin
            rx_cnt <= rx_cnt + 16'h0001;
         end
         if (rx_bad) begin
            alive_o <= 1'b0;
            if (err_cnt == 2'h1) begin
               err2_o <= 1'b1;
               err_cnt <= 2'h0;
            end else begin
               err_cnt <= 2'h1;
            end
         end else if (ls_edge) begin
            err_cnt <= 2'h0;
            alive_o <= 1'b1;
         end
      end
   end
endmodule // sisup_wdog

// >>> verif/sisup_checker.sv
// Port assertions for the supply and internal supervisor.
`timescale 1ns/1ps
module sisup_checker (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire ack_o,
   input wire irq_o,
   input wire pri_supply_low_i,
   input wire sec_supply_low_i,
   input wire sec_below_reset_i,
   input wire primary_ref_pin_fail_i,
   input wire secondary_ref_pin_fail_i,
   input wire sec_par_inject_i,
   input wire reset_ready_out_n_o,
   input wire fault_b_out_n_o,
   input wire turn_off_req_o,
   input wire sec_reset_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A fault held for three edges has passed the two-stage synchroniser.
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack wider than one cycle");
   property p_ack_answer; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("no ack one cycle after request");
   property p_pri_low; pri_supply_low_i [*3] |-> !reset_ready_out_n_o && turn_off_req_o; endproperty
   a_pri_low: assert property (p_pri_low) else $error("primary undervoltage ignored");
   property p_sec_low; sec_supply_low_i [*3] |-> !fault_b_out_n_o && turn_off_req_o; endproperty
   a_sec_low: assert property (p_sec_low) else $error("secondary undervoltage ignored");
   property p_sec_rst; sec_below_reset_i [*3] |-> sec_reset_o; endproperty
   a_sec_rst: assert property (p_sec_rst) else $error("secondary not held in reset");
   property p_pref; primary_ref_pin_fail_i [*3] |-> !reset_ready_out_n_o; endproperty
   a_pref: assert property (p_pref) else $error("primary ref failure ignored");
   property p_sref; secondary_ref_pin_fail_i [*3] |-> turn_off_req_o && sec_reset_o; endproperty
   a_sref: assert property (p_sref) else $error("secondary ref failure ignored");
   property p_spar; sec_par_inject_i [*3] |-> turn_off_req_o && sec_reset_o; endproperty
   a_spar: assert property (p_spar) else $error("secondary parity failure ignored");
   c_ack: cover property (cyc_i && stb_i ##1 ack_o);
   c_fault_b: cover property ($fell(fault_b_out_n_o));
   c_irq: cover property ($rose(irq_o));
endmodule // sisup_checker
bind sisup_top sisup_checker sisup_checker_inst (.*);

// >>> verif/sisup_host.sv
// Host model that runs classic Wishbone cycles on the register port.
`timescale 1ns/1ps
module sisup_host (
   input wire clk_i,
   input wire ack_i,
   input wire [31:0] rdat_i,
   output reg cyc_o = 1'b0,
   output reg stb_o = 1'b0,
   output reg we_o = 1'b0,
   output reg [3:0] adr_o = 4'h0,
   output reg [3:0] sel_o = 4'h0,
   output reg [31:0] dat_o = 32'h0
);
   // Caller enters just after a rising edge; request holds until ack is sampled.
   task xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      begin
         cyc_o <= 1'b1;
         stb_o <= 1'b1;
         we_o <= w;
         adr_o <= a;
         sel_o <= 4'h1;
         dat_o <= d;
         @(posedge clk_i);
         while (ack_i !== 1'b1) @(posedge clk_i);
         q = rdat_i;
         cyc_o <= 1'b0;
         stb_o <= 1'b0;
         @(posedge clk_i);
      end
   endtask
endmodule // sisup_host

// >>> verif/sisup_top_bench.sv
// Self-checking bench for the supply and internal supervisor.
`timescale 1ns/1ps
`include "sisup_defs.vh"
module sisup_top_bench;
   logic clk_i, rst_i = 1'b1, pri_lo = 1'b0, sbr = 1'b0, pref = 1'b0, sref = 1'b0, spar = 1'b0;
   logic [3:0] sup = 4'h0;
   wire cyc, stb, we, ack, irq, rr_n, fb_n, toff, srst, alive;
   wire [3:0] adr, sel;
   wire [31:0] wdat, rdat;
   logic [31:0] q;
   int failures = 0, check_count = 0;
   sisup_top #(.LS_PERIOD(20), .LS_WIN_MIN(10), .LS_WIN_MAX(40)) sisup_top_inst (.clk_i(clk_i),
      .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
      .dat_o(rdat), .ack_o(ack), .irq_o(irq), .pri_supply_low_i(pri_lo),
      .sec_supply_low_i(sup[0]), .sec_supply_high_i(sup[1]), .neg_supply_low_i(sup[2]),
      .neg_supply_high_i(sup[3]), .sec_below_reset_i(sbr), .primary_ref_pin_fail_i(pref),
      .secondary_ref_pin_fail_i(sref), .sec_par_inject_i(spar), .reset_ready_out_n_o(rr_n),
      .fault_b_out_n_o(fb_n), .turn_off_req_o(toff), .sec_reset_o(srst),
      .link_alive_status_o(alive));
   sisup_host sisup_host_inst (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc),
      .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      sisup_host_inst.xfer(1'b1, a, d, q);
   endtask
   task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
      sisup_host_inst.xfer(1'b0, a, 32'h0, q);
      chk(n, e, q & m);
   endtask
   // Pins pass a two-stage synchroniser, so four edges always suffice.
   task settle();
      repeat (4) @(posedge clk_i);
   endtask
   task t_reset();
      rd(`SISUP_ADR_STAT, 32'hffffffff, 32'h0, "status reset");
      rd(`SISUP_ADR_CFG, 32'hffffffff, 32'h0, "cfg reset");
      rd(4'hf, 32'hffffffff, 32'h0, "unmapped read");
      chk("turn_off idle", 1, toff);
      chk("fault_b idle", 1, fb_n);
      wr(`SISUP_ADR_CFG, 32'h3);
      rd(`SISUP_ADR_CFG, 32'hffffffff, 32'h3, "cfg readback");
      chk("turn_off enabled", 0, toff);
   endtask
   task t_pri_low();
      pri_lo <= 1'b1;
      settle();
      chk("ready low", 0, rr_n);
      chk("turn_off pri", 1, toff);
      pri_lo <= 1'b0;
      settle();
      chk("ready back", 1, rr_n);
      // The primary hold upsets the lifesign loop, so let it settle before the clearing read.
      repeat (200) @(posedge clk_i);
      rd(`SISUP_ADR_STAT, 32'h1, 32'h1, "reset seen");
      rd(`SISUP_ADR_STAT, 32'h1, 32'h0, "reset seen cleared");
      wr(`SISUP_ADR_CFG, 32'h3);
   endtask
   task t_supply();
      for (int i = 0; i < 4; i++) begin
         sup <= 4'h1 << i;
         settle();
         chk("fault_b supply", 0, fb_n);
         chk("turn_off supply", 1, toff);
         rd(`SISUP_ADR_LIVE, 32'hf, 32'h1 << i, "live bits");
         sup <= 4'h0;
         settle();
         rd(`SISUP_ADR_LIVE, 32'hf, 32'h0, "live clear");
         rd(`SISUP_ADR_STAT, 32'h1e, 32'h2 << i, "supply flag");
         wr(`SISUP_ADR_CFG, 32'h3);
         chk("re-enable", 0, toff);
      end
   endtask
   task t_neg_off();
      wr(`SISUP_ADR_CFG, 32'h2);
      sup <= 4'h8;
      settle();
      chk("turn_off neg off", 0, toff);
      chk("fault_b neg off", 1, fb_n);
      sup <= 4'h0;
      settle();
      rd(`SISUP_ADR_STAT, 32'h1e, 32'h10, "neg high flag");
      wr(`SISUP_ADR_CFG, 32'h3);
   endtask
   task t_irq();
      wr(`SISUP_ADR_MASK, 32'h2);
      rd(`SISUP_ADR_PAR, 32'h3, 32'h2, "mask parity");
      sup <= 4'h1;
      settle();
      sup <= 4'h0;
      settle();
      chk("irq set", 1, irq);
      rd(`SISUP_ADR_STAT, 32'h2, 32'h2, "irq flag");
      chk("irq clear", 0, irq);
      wr(`SISUP_ADR_MASK, 32'h0);
      wr(`SISUP_ADR_CFG, 32'h3);
   endtask
   task t_die_faults();
      sbr <= 1'b1;
      settle();
      chk("sec held", 1, srst);
      sbr <= 1'b0;
      repeat (200) @(posedge clk_i);
      chk("link alive", 1, alive);
      sref <= 1'b1;
      settle();
      chk("sref turn_off", 1, toff);
      repeat (200) @(posedge clk_i);
      chk("link lost", 0, alive);
      chk("fault_b link", 0, fb_n);
      sref <= 1'b0;
      repeat (200) @(posedge clk_i);
      chk("link back", 1, alive);
      rd(`SISUP_ADR_LIVE, 32'h10, 32'h10, "live link bit");
      rd(`SISUP_ADR_STAT, 32'h20, 32'h20, "primary loss flag");
      pref <= 1'b1;
      settle();
      chk("pref ready", 0, rr_n);
      repeat (200) @(posedge clk_i);
      pref <= 1'b0;
      repeat (200) @(posedge clk_i);
      rd(`SISUP_ADR_STAT, 32'h40, 32'h40, "secondary loss flag");
      spar <= 1'b1;
      settle();
      chk("parity turn_off", 1, toff);
      chk("parity sec held", 1, srst);
      spar <= 1'b0;
   endtask
   task wrap_up();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_pri_low();
      t_supply();
      t_neg_off();
      t_irq();
      t_die_faults();
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      wrap_up();
   end
endmodule // sisup_top_bench
